// [design/aam_pkg.sv]
// Function
// - with the destination filter at any, the frame's destination address is ignored.
// - with the destination filter at host, the destination must equal the set address.
// - with the destination filter at network, address and set address agree under the mask.
// - the opcode selector is any, ARP opcodes, RARP opcodes or any other opcode.
// - the request/reply selector is any, a request of either kind, or a reply of either kind.
// - the sender address filter is any, host equality, or equality under the sender mask.
// - the target address filter is any, host equality, or equality under the target mask.
// - on ARP frames, setting 0 wants sender hw address unlike source MAC, 1 alike, any free.
// - on RARP frames, setting 0 wants target hw address unlike source MAC, 1 alike, any free.
// - setting 1 wants lengths 6 and 4, setting 0 refuses them, any ignores them.
// - setting 1 wants hardware type 1, setting 0 refuses it, any ignores it.
// - setting 1 wants protocol type 0x800, setting 0 refuses it, any ignores it.
package aam_pkg;
   localparam int AAM_AW = 8;
   localparam logic [7:0] AAM_CTRL_OFF = 8'h00;
   localparam logic [7:0] AAM_ADDR0_OFF = 8'h04;
   localparam logic [7:0] AAM_MASK0_OFF = 8'h08;
   localparam logic [7:0] AAM_PAIR_STEP = 8'h08;
   localparam logic [7:0] AAM_HITS_OFF = 8'h1c;
   localparam logic [7:0] AAM_FRAMES_OFF = 8'h20;
   localparam int AAM_NUM_IPF = 3;
   localparam int F_DST = 0;
   localparam int F_OP = 2;
   localparam int F_RR = 4;
   localparam int F_SND = 6;
   localparam int F_TIP = 8;
   localparam int F_SHA = 10;
   localparam int F_THA = 12;
   localparam int F_LEN = 14;
   localparam int F_HRD = 16;
   localparam int F_PRO = 18;
   localparam int F_EN = 31;
   localparam logic [31:0] AAM_CTRL_RST = 32'h000a_a800;
   localparam logic [31:0] AAM_ADDR_RST = 32'h0000_0000;
   localparam logic [31:0] AAM_MASK_RST = 32'hffff_ffff;
   localparam logic [1:0] IPF_ANY = 2'h0;
   localparam logic [1:0] IPF_HOST = 2'h1;
   localparam logic [1:0] IPF_NET = 2'h2;
   localparam logic [1:0] OPS_ANY = 2'h0;
   localparam logic [1:0] OPS_ARP = 2'h1;
   localparam logic [1:0] OPS_RARP = 2'h2;
   localparam logic [1:0] OPS_OTHER = 2'h3;
   localparam logic [1:0] RR_ANY = 2'h0;
   localparam logic [1:0] RR_REQ = 2'h1;
   localparam logic [1:0] RR_REP = 2'h2;
   localparam logic [1:0] TRI_ZERO = 2'h0;
   localparam logic [1:0] TRI_ONE = 2'h1;
   localparam logic [1:0] TRI_ANY = 2'h2;
   localparam logic [15:0] OPC_ARP_REQ = 16'h0001;
   localparam logic [15:0] OPC_ARP_REP = 16'h0002;
   localparam logic [15:0] OPC_RARP_REQ = 16'h0003;
   localparam logic [15:0] OPC_RARP_REP = 16'h0004;
   localparam logic [7:0] HLN_ETH = 8'h06;
   localparam logic [7:0] PLN_IP4 = 8'h04;
   localparam logic [15:0] HRD_ETH = 16'h0001;
   localparam logic [15:0] PRO_IP = 16'h0800;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic arp;
      logic [15:0] hrd;
      logic [15:0] pro;
      logic [7:0] hln;
      logic [7:0] pln;
      logic [15:0] opcode;
      logic [47:0] sha;
      logic [47:0] tha;
      logic [47:0] frame_source_mac;
      logic [31:0] spa;
      logic [31:0] tpa;
      logic [31:0] dst_ip;
   } aam_frame_type;
endpackage : aam_pkg

// [design/aam_ip_filter.sv]
`timescale 1ns/1ns
module aam_ip_filter (
   input wire logic [1:0] mode,
   input wire logic [31:0] cfg_addr,
   input wire logic [31:0] cfg_mask,
   input wire logic [31:0] frame_addr,
   output logic ok
);
   import aam_pkg::*;
   wire logic [31:0] diff = frame_addr ^ cfg_addr;
   wire logic host_eq = (diff == 32'h0000_0000);
   wire logic net_eq = ((diff & cfg_mask) == 32'h0000_0000);
   // code 3 is unused and behaves as don't-care
   assign ok = (mode == IPF_HOST) ? host_eq :
               (mode == IPF_NET) ? net_eq : 1'b1;
endmodule : aam_ip_filter

// [design/aam_tri_check.sv]
`timescale 1ns/1ns
module aam_tri_check (
   input wire logic [1:0] setting,
   input wire logic applies,
   input wire logic cond,
   output logic ok
);
   import aam_pkg::*;
   // frames outside the check's scope always pass; code 3 acts as any
   assign ok = !applies ? 1'b1 :
               (setting == TRI_ONE) ? cond :
               (setting == TRI_ZERO) ? !cond : 1'b1;
endmodule : aam_tri_check

// [design/aam_matcher.sv]
`timescale 1ns/1ns
module aam_matcher (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [aam_pkg::AAM_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [aam_pkg::AAM_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic frame_valid,
   input wire aam_pkg::aam_frame_type frame,
   output logic match_valid,
   output logic match_hit
);
   import aam_pkg::*;

   // register index: 0 ctrl, 1..6 addr/mask pairs, 7 hits, 8 frames; 15 unmapped
   function automatic logic [3:0] reg_index(input logic [AAM_AW-1:0] a);
      logic [3:0] idx;
      idx = 4'hf;
      if (a[1:0] == 2'h0) begin
         if (a == AAM_CTRL_OFF) idx = 4'h0;
         if (a >= AAM_ADDR0_OFF && a < AAM_HITS_OFF) idx = 4'(a[AAM_AW-1:2]);
         if (a == AAM_HITS_OFF) idx = 4'h7;
         if (a == AAM_FRAMES_OFF) idx = 4'h8;
      end
      return idx;
   endfunction : reg_index

   function automatic logic [31:0] strobe_merge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return r;
   endfunction : strobe_merge

   logic [31:0] ctrl;
   logic [31:0] ip_addr [AAM_NUM_IPF];
   logic [31:0] ip_mask [AAM_NUM_IPF];
   logic [31:0] hit_count;
   logic [31:0] frame_count;

   // ---------------- write channel ----------------
   logic aw_got;
   logic w_got;
   logic [AAM_AW-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // address and data may come in either order; each is held until both are in
   assign s_axi_awready = !aw_got;
   assign s_axi_wready = !w_got;
   wire logic do_write = aw_got && w_got && !s_axi_bvalid;
   wire logic [3:0] w_idx = reg_index(aw_addr);
   wire logic w_map = (w_idx != 4'hf);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_got <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_got <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= w_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   wire logic wr_ctrl = do_write && (w_idx == 4'h0);
   wire logic wr_hits = do_write && (w_idx == 4'h7);
   wire logic wr_frames = do_write && (w_idx == 4'h8);

   always_ff @(posedge aclk) begin
      if (!aresetn) ctrl <= AAM_CTRL_RST;
      else if (wr_ctrl) ctrl <= strobe_merge(ctrl, w_data, w_strb);
   end

   // addr/mask pairs: dest at 0x04/0x08, sender 0x0c/0x10, target 0x14/0x18
   for (genvar k = 0; k < AAM_NUM_IPF; k++) begin : g_ipreg
      localparam logic [3:0] AI = 4'(2 * k + 1);
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            ip_addr[k] <= AAM_ADDR_RST;
            ip_mask[k] <= AAM_MASK_RST;
         end else if (do_write && w_idx == AI) begin
            ip_addr[k] <= strobe_merge(ip_addr[k], w_data, w_strb);
         end else if (do_write && w_idx == AI + 4'h1) begin
            ip_mask[k] <= strobe_merge(ip_mask[k], w_data, w_strb);
         end
      end
   end

   // ---------------- read channel ----------------
   assign s_axi_arready = !s_axi_rvalid;
   wire logic [3:0] r_idx = reg_index(s_axi_araddr);
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (r_idx)
         4'h0: rd_mux = ctrl;
         4'h1: rd_mux = ip_addr[0];
         4'h2: rd_mux = ip_mask[0];
         4'h3: rd_mux = ip_addr[1];
         4'h4: rd_mux = ip_mask[1];
         4'h5: rd_mux = ip_addr[2];
         4'h6: rd_mux = ip_mask[2];
         4'h7: rd_mux = hit_count;
         4'h8: rd_mux = frame_count;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= (r_idx == 4'hf) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- classification ----------------
   wire logic [1:0] dst_mode = ctrl[F_DST +: 2];
   wire logic [1:0] op_sel = ctrl[F_OP +: 2];
   wire logic [1:0] rr_sel = ctrl[F_RR +: 2];
   wire logic entry_en = ctrl[F_EN];

   wire logic op_is_arp = frame.opcode == OPC_ARP_REQ || frame.opcode == OPC_ARP_REP;
   wire logic op_is_rarp = frame.opcode == OPC_RARP_REQ || frame.opcode == OPC_RARP_REP;
   wire logic op_is_req = frame.opcode == OPC_ARP_REQ || frame.opcode == OPC_RARP_REQ;
   wire logic op_is_rep = frame.opcode == OPC_ARP_REP || frame.opcode == OPC_RARP_REP;

   logic dst_ok;
   logic snd_ok;
   logic tip_ok;
   aam_ip_filter u_dst_filter (
      .mode(dst_mode), .cfg_addr(ip_addr[0]), .cfg_mask(ip_mask[0]),
      .frame_addr(frame.dst_ip), .ok(dst_ok));
   aam_ip_filter u_sender_filter (
      .mode(ctrl[F_SND +: 2]), .cfg_addr(ip_addr[1]), .cfg_mask(ip_mask[1]),
      .frame_addr(frame.spa), .ok(snd_ok));
   aam_ip_filter u_target_filter (
      .mode(ctrl[F_TIP +: 2]), .cfg_addr(ip_addr[2]), .cfg_mask(ip_mask[2]),
      .frame_addr(frame.tpa), .ok(tip_ok));

   wire logic op_ok = (op_sel == OPS_ARP) ? op_is_arp :
                      (op_sel == OPS_RARP) ? op_is_rarp :
                      (op_sel == OPS_OTHER) ? !(op_is_arp || op_is_rarp) : 1'b1;
   // code 3 of this selector is unused and treated as any
   wire logic rr_ok = (rr_sel == RR_REQ) ? op_is_req :
                      (rr_sel == RR_REP) ? op_is_rep : 1'b1;

   logic sha_ok;
   logic tha_ok;
   logic len_ok;
   logic hrd_ok;
   logic pro_ok;
   aam_tri_check u_sender_hw_source_check (
      .setting(ctrl[F_SHA +: 2]), .applies(op_is_arp),
      .cond(frame.sha == frame.frame_source_mac), .ok(sha_ok));
   aam_tri_check u_target_hw_source_check (
      .setting(ctrl[F_THA +: 2]), .applies(op_is_rarp),
      .cond(frame.tha == frame.frame_source_mac), .ok(tha_ok));
   aam_tri_check u_address_length_check (
      .setting(ctrl[F_LEN +: 2]), .applies(frame.arp),
      .cond(frame.hln == HLN_ETH && frame.pln == PLN_IP4), .ok(len_ok));
   aam_tri_check u_hw_type_check (
      .setting(ctrl[F_HRD +: 2]), .applies(frame.arp),
      .cond(frame.hrd == HRD_ETH), .ok(hrd_ok));
   aam_tri_check u_proto_type_check (
      .setting(ctrl[F_PRO +: 2]), .applies(frame.arp),
      .cond(frame.pro == PRO_IP), .ok(pro_ok));

   // this entry only ever classifies ARP/RARP frames; a disabled entry never hits
   wire logic all_ok = entry_en && frame.arp && dst_ok && op_ok && rr_ok && snd_ok
                       && tip_ok && sha_ok && tha_ok && len_ok && hrd_ok && pro_ok;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_valid <= 1'b0;
         match_hit <= 1'b0;
      end else begin
         match_valid <= frame_valid;
         match_hit <= frame_valid && all_ok;
      end
   end

   // a count event in the clearing cycle survives: the clear loads one
   wire logic hit_evt = frame_valid && all_ok;
   always_ff @(posedge aclk) begin
      if (!aresetn) hit_count <= '0;
      else if (wr_hits) hit_count <= {31'h0000_0000, hit_evt};
      else if (hit_evt) hit_count <= hit_count + 32'h0000_0001;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) frame_count <= '0;
      else if (wr_frames) frame_count <= {31'h0000_0000, frame_valid};
      else if (frame_valid) frame_count <= frame_count + 32'h0000_0001;
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_frame_in;
      frame_valid && entry_en && frame.arp;
   endsequence

   sequence s_rest_ok;
      op_ok && rr_ok && snd_ok && tip_ok && sha_ok && tha_ok && len_ok && hrd_ok && pro_ok;
   endsequence

   dst_any_a: assert property (
      s_frame_in ##0 s_rest_ok ##0 (dst_mode == IPF_ANY) |=> match_hit)
      else $error("dest filter any did not hit");

   dst_host_a: assert property (
      frame_valid && dst_mode == IPF_HOST && frame.dst_ip != ip_addr[0] |=> !match_hit)
      else $error("dest host mismatch hit");

   dst_net_a: assert property (
      frame_valid && dst_mode == IPF_NET
      && ((frame.dst_ip ^ ip_addr[0]) & ip_mask[0]) != 32'h0000_0000 |=> !match_hit)
      else $error("dest network mismatch hit");

   op_sel_a: assert property (
      frame_valid && op_sel == OPS_OTHER && (frame.opcode == OPC_ARP_REQ
      || frame.opcode == OPC_RARP_REP) |=> !match_hit)
      else $error("other opcode selector passed a known opcode");

   req_rep_a: assert property (
      frame_valid && rr_sel == RR_REQ && frame.opcode != OPC_ARP_REQ
      && frame.opcode != OPC_RARP_REQ |=> !match_hit)
      else $error("request selector passed a non-request");

   sender_ip_a: assert property (
      ctrl[F_SND +: 2] == IPF_HOST && frame.spa != ip_addr[1] |-> !snd_ok)
      else $error("sender host filter passed");

   target_ip_a: assert property (
      ctrl[F_TIP +: 2] == IPF_NET
      && ((frame.tpa ^ ip_addr[2]) & ip_mask[2]) == 32'h0000_0000 |-> tip_ok)
      else $error("target network filter refused a match");

   sha_check_a: assert property (
      frame_valid && op_is_arp && ctrl[F_SHA +: 2] == TRI_ZERO
      && frame.sha == frame.frame_source_mac |=> !match_hit)
      else $error("sender hw check 0 passed equal address");

   tha_check_a: assert property (
      frame_valid && op_is_rarp && ctrl[F_THA +: 2] == TRI_ONE
      && frame.tha != frame.frame_source_mac |=> !match_hit)
      else $error("target hw check 1 passed unequal address");

   len_check_a: assert property (
      frame_valid && ctrl[F_LEN +: 2] == TRI_ONE
      && (frame.hln != HLN_ETH || frame.pln != PLN_IP4) |=> !match_hit)
      else $error("length check passed wrong lengths");

   hrd_check_a: assert property (
      frame_valid && ctrl[F_HRD +: 2] == TRI_ZERO && frame.hrd == HRD_ETH |=> !match_hit)
      else $error("hardware type 0 passed ethernet");

   pro_check_a: assert property (
      frame_valid && ctrl[F_PRO +: 2] == TRI_ONE && frame.pro != PRO_IP |=> !match_hit)
      else $error("protocol type 1 passed non-ip");

   hit_all_a: assert property (
      frame_valid |=> match_valid && (match_hit == $past(all_ok)))
      else $error("hit does not follow all filters");

   hit_count_a: assert property (
      match_hit && !$past(wr_hits) |-> hit_count == $past(hit_count) + 32'h0000_0001)
      else $error("hit counter missed a hit");

   dst_host_hit_a: assert property (
      s_frame_in ##0 s_rest_ok ##0 (dst_mode == IPF_HOST && frame.dst_ip == ip_addr[0])
      |=> match_hit)
      else $error("dest host match did not hit");

   reply_sel_a: assert property (
      frame_valid && rr_sel == RR_REP && frame.opcode != OPC_ARP_REP
      && frame.opcode != OPC_RARP_REP |=> !match_hit)
      else $error("reply selector passed a non-reply");

   len_zero_a: assert property (
      frame_valid && ctrl[F_LEN +: 2] == TRI_ZERO
      && frame.hln == HLN_ETH && frame.pln == PLN_IP4 |=> !match_hit)
      else $error("length check 0 passed standard lengths");

   hrd_one_a: assert property (
      frame_valid && ctrl[F_HRD +: 2] == TRI_ONE && frame.hrd != HRD_ETH |=> !match_hit)
      else $error("hardware type 1 passed non-ethernet");

   pro_zero_a: assert property (
      frame_valid && ctrl[F_PRO +: 2] == TRI_ZERO && frame.pro == PRO_IP |=> !match_hit)
      else $error("protocol type 0 passed ip");

   frame_count_a: assert property (
      frame_valid && !wr_frames |=> frame_count == $past(frame_count) + 32'h0000_0001)
      else $error("frame counter missed a frame");
endmodule : aam_matcher

// [tb/aam_frame_src.sv]
`timescale 1ns/1ns
module aam_frame_src (
   input wire logic aclk,
   output logic frame_valid,
   output aam_pkg::aam_frame_type frame,
   input wire logic match_valid,
   input wire logic match_hit
);
   import aam_pkg::*;
   logic got_q[$];
   initial begin
      frame_valid = 1'b0;
      frame = '0;
   end
   // one frame per edge, the parser never stalls
   task automatic send(input aam_frame_type f);
      frame_valid <= 1'b1;
      frame <= f;
      @(posedge aclk);
   endtask : send
   // released fields scrambled so a stale frame never looks plausible
   task automatic idle();
      frame_valid <= 1'b0;
      frame <= ~frame;
   endtask : idle
   always @(posedge aclk) begin
      if (match_valid === 1'b1) begin
         got_q.push_back(match_hit);
      end
   end
endmodule : aam_frame_src

// [tb/test_ace_arp_ip_matcher.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module test_ace_arp_ip_matcher;
   import aam_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, frame_valid, match_valid, match_hit;
   logic [AAM_AW-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, base;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   aam_frame_type frame, f0, f;
   logic exp_q[$];
   int n_mismatch = 0;
   int n_compared = 0;
   int n_hits = 0;
   int n_frames = 0;
   localparam logic [31:0] IP_V = 32'hc0a8_0164;
   localparam int IPF_POS[3] = '{F_DST, F_SND, F_TIP};
   localparam int TRI_POS[5] = '{F_SHA, F_THA, F_LEN, F_HRD, F_PRO};
   localparam logic [31:0] DELTA[3] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0100};

   aam_matcher dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_valid(frame_valid),
      .frame(frame), .match_valid(match_valid), .match_hit(match_hit));
   aam_frame_src src_u (.aclk(aclk), .frame_valid(frame_valid), .frame(frame),
      .match_valid(match_valid), .match_hit(match_hit));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   task automatic timeout();
      n_mismatch++;
      $display("bus wait ran out at t=%0t", $time);
      tally_and_finish();
   endtask : timeout

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
         input logic [1:0] er);
      logic ta, tw, done;
      logic [1:0] resp;
      done = 1'b0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 64 && !done; n++) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         done = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      if (!done) timeout();
      `CHK(resp, er)
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, done;
      logic [31:0] d;
      logic [1:0] resp;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 64 && !done; n++) begin
         @(negedge aclk);
         ta = arvalid && arready;
         done = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
      if (!done) timeout();
      `CHK(d, ed)
      `CHK(resp, er)
   endtask : rd_chk

   task automatic set_ctrl(input int pos, input logic [1:0] m);
      logic [31:0] c;
      c = base;
      c[pos +: 2] = m;
      wr(AAM_CTRL_OFF, c, 4'hf, RESP_OKAY);
   endtask : set_ctrl

   task automatic fr(input aam_frame_type t, input logic e);
      src_u.send(t);
      exp_q.push_back(e);
      if (e) n_hits++;
      n_frames++;
   endtask : fr

   // the monitor takes each answer one edge after the edge that launches it
   task automatic flush();
      logic g, e;
      src_u.idle();
      repeat (2) @(posedge aclk);
      #1;
      `CHK(src_u.got_q.size(), exp_q.size())
      while (exp_q.size() > 0 && src_u.got_q.size() > 0) begin
         g = src_u.got_q.pop_front();
         e = exp_q.pop_front();
         `CHK(g, e)
      end
      src_u.got_q.delete();
      exp_q.delete();
   endtask : flush

   function automatic aam_frame_type ipset(input int i, input logic [31:0] v);
      aam_frame_type t;
      t = f0;
      if (i == 0) t.dst_ip = v;
      if (i == 1) t.spa = v;
      if (i == 2) t.tpa = v;
      return t;
   endfunction : ipset

   function automatic logic sel_exp(input int k, input int s, input int op);
      logic a, r, q, p;
      a = op == 1 || op == 2;
      r = op == 3 || op == 4;
      q = op == 1 || op == 3;
      p = op == 2 || op == 4;
      if (k == 0) return s == 0 || (s == 1 && a) || (s == 2 && r) || (s == 3 && !a && !r);
      return s == 0 || s == 3 || (s == 1 && q) || (s == 2 && p);
   endfunction : sel_exp

   function automatic aam_frame_type tri_frame(input int j, input logic c);
      aam_frame_type t;
      t = f0;
      case (j)
         0: t.sha = c ? t.frame_source_mac : ~t.frame_source_mac;
         1: begin
            t.opcode = OPC_RARP_REP;
            t.tha = c ? t.frame_source_mac : ~t.frame_source_mac;
         end
         2: t.pln = c ? PLN_IP4 : 8'h10;
         3: t.hrd = c ? HRD_ETH : 16'h0006;
         default: t.pro = c ? PRO_IP : 16'h86dd;
      endcase
      return t;
   endfunction : tri_frame

   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
      f0 = '{arp: 1'b1, hrd: HRD_ETH, pro: PRO_IP, hln: HLN_ETH, pln: PLN_IP4,
         opcode: OPC_ARP_REQ, sha: 48'h0200_0000_0a01, tha: 48'h0000_0000_0000,
         frame_source_mac: 48'h0200_0000_0a01, spa: 32'h0a00_0002, tpa: 32'h0a00_0003,
         dst_ip: 32'h0a00_0001};
      base = AAM_CTRL_RST | 32'h8000_0000;
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(AAM_CTRL_OFF, AAM_CTRL_RST, RESP_OKAY);
      for (int i = 0; i < AAM_NUM_IPF; i++) begin
         rd_chk(AAM_ADDR0_OFF + AAM_PAIR_STEP * 8'(i), AAM_ADDR_RST, RESP_OKAY);
         rd_chk(AAM_MASK0_OFF + AAM_PAIR_STEP * 8'(i), AAM_MASK_RST, RESP_OKAY);
      end
      rd_chk(AAM_HITS_OFF, 32'h0000_0000, RESP_OKAY);
      rd_chk(8'h24, 32'h0000_0000, RESP_SLVERR);
      wr(8'h24, 32'hffff_ffff, 4'hf, RESP_SLVERR);
      wr(8'h02, 32'h0000_0000, 4'hf, RESP_SLVERR);
      rd_chk(AAM_CTRL_OFF, AAM_CTRL_RST, RESP_OKAY);
      $display("test registers done");
      fr(f0, 1'b0);
      flush();
      wr(AAM_CTRL_OFF, base, 4'hf, RESP_OKAY);
      f = f0;
      f.arp = 1'b0;
      fr(f0, 1'b1);
      fr(f, 1'b0);
      fr(f0, 1'b1);
      flush();
      $display("test enable done");
      for (int i = 0; i < AAM_NUM_IPF; i++) begin
         wr(AAM_ADDR0_OFF + AAM_PAIR_STEP * 8'(i), IP_V, 4'hf, RESP_OKAY);
         wr(AAM_MASK0_OFF + AAM_PAIR_STEP * 8'(i), 32'hffff_ff00, 4'hf, RESP_OKAY);
         for (int m = 0; m < 4; m++) begin
            set_ctrl(IPF_POS[i], 2'(m));
            for (int d = 0; d < 3; d++) begin
               fr(ipset(i, IP_V ^ DELTA[d]), m == 1 ? d == 0 : m == 2 ? d != 2 : 1'b1);
            end
            flush();
         end
      end
      $display("test address filters done");
      for (int k = 0; k < 2; k++) begin
         for (int s = 0; s < 4; s++) begin
            set_ctrl(k == 0 ? F_OP : F_RR, 2'(s));
            for (int op = 0; op < 6; op++) begin
               f = f0;
               f.opcode = 16'(op);
               fr(f, sel_exp(k, s, op));
            end
            flush();
         end
      end
      $display("test opcode selectors done");
      for (int j = 0; j < 5; j++) begin
         for (int s = 0; s < 4; s++) begin
            set_ctrl(TRI_POS[j], 2'(s));
            for (int c = 0; c < 2; c++) begin
               fr(tri_frame(j, c[0]), s >= 2 || s == c);
            end
            flush();
         end
      end
      set_ctrl(F_SHA, TRI_ONE);
      f = tri_frame(0, 1'b0);
      f.opcode = OPC_RARP_REQ;
      fr(f, 1'b1);
      flush();
      $display("test field checks done");
      wr(AAM_MASK0_OFF, 32'h0000_0000, 4'h2, RESP_OKAY);
      rd_chk(AAM_MASK0_OFF, 32'hffff_0000, RESP_OKAY);
      rd_chk(AAM_HITS_OFF, 32'(n_hits), RESP_OKAY);
      wr(AAM_HITS_OFF, 32'h1234_5678, 4'hf, RESP_OKAY);
      rd_chk(AAM_HITS_OFF, 32'h0000_0000, RESP_OKAY);
      rd_chk(AAM_FRAMES_OFF, 32'(n_frames), RESP_OKAY);
      wr(AAM_FRAMES_OFF, 32'h1234_5678, 4'hf, RESP_OKAY);
      rd_chk(AAM_FRAMES_OFF, 32'h0000_0000, RESP_OKAY);
      $display("test counters done");
      tally_and_finish();
   end
endmodule : test_ace_arp_ip_matcher
